// *** dsp_decode_pkg.sv ***
// Constants, opcode encodings and types for the accumulator-group instruction decoder.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package dsp_decode_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_OPERAND = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DADDR = 8'h10;
  localparam logic [7:0] OFS_SHIFT_LO = 8'h14;
  localparam logic [7:0] OFS_SHIFT_HI = 8'h18;
  localparam logic [7:0] OFS_AUX_BASE = 8'h20;
  localparam int AUX_SEL_LSB = 2;
  localparam int AUX_BLOCK_LSB = 5;

  // Control register layout
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_AUXPTR_LSB = 9;
  localparam int CTRL_SIGNEXT_BIT = 12;
  localparam int PAGE_W = 9;
  localparam int AUXPTR_W = 3;

  // Instruction word fields
  localparam int MODE_BIT = 7;
  localparam int OFFSET_W = 7;
  localparam int NEXT_AUXPTR_BIT = 3;
  localparam int MOD_LSB = 4;
  localparam int SHIFT_LSB = 8;

  // Indirect modification codes in bits 6-4
  localparam logic [2:0] MOD_NONE = 3'h0;
  localparam logic [2:0] MOD_DEC = 3'h1;
  localparam logic [2:0] MOD_INC = 3'h2;
  localparam logic [2:0] MOD_REV_DEC = 3'h4;
  localparam logic [2:0] MOD_SUB_IDX = 3'h5;
  localparam logic [2:0] MOD_ADD_IDX = 3'h6;
  localparam logic [2:0] MOD_REV_INC = 3'h7;

  // Opcode encodings
  localparam logic [3:0] NIB_SUM = 4'h0;
  localparam logic [3:0] NIB_MINUS = 4'h1;
  localparam logic [3:0] NIB_LOAD = 4'h2;
  localparam logic [3:0] NIB_LONG = 4'hd;
  localparam logic [4:0] TOP_STORE_HIGH = 5'h0d;
  localparam logic [4:0] TOP_STORE_LOW = 5'h0c;
  localparam logic [7:0] LO_SUM_LONG = 8'h02;
  localparam logic [7:0] LO_MINUS_LONG = 8'h03;
  localparam logic [7:0] LO_CONJ_LONG = 8'h04;
  localparam logic [7:0] HI_SUM_SHORT = 8'hcc;
  localparam logic [7:0] HI_MINUS_SHORT = 8'hcd;
  localparam logic [7:0] HI_LOAD_SHORT = 8'hca;
  localparam logic [7:0] HI_ACC_ONLY = 8'hce;
  localparam logic [7:0] LO_MAGNITUDE = 8'h1b;
  localparam logic [7:0] LO_INVERT = 8'h27;
  localparam logic [7:0] LO_ROTATE_LEFT = 8'h34;
  localparam logic [7:0] LO_SHIFT_LEFT = 8'h18;
  localparam logic [7:0] HI_SUM_CARRY = 8'h43;
  localparam logic [7:0] HI_SUM_HIGH = 8'h48;
  localparam logic [7:0] HI_SUM_ULOW = 8'h49;
  localparam logic [7:0] HI_SUM_TSHIFT = 8'h4a;
  localparam logic [7:0] HI_CONJ = 8'h4e;
  localparam logic [7:0] HI_DISJ = 8'h4d;
  localparam logic [7:0] HI_MINUS_BORROW = 8'h4f;
  localparam logic [7:0] HI_COND_MINUS = 8'h47;
  localparam logic [7:0] HI_MINUS_HIGH = 8'h44;
  localparam logic [7:0] HI_MINUS_ULOW = 8'h45;
  localparam logic [7:0] HI_LOAD_TSHIFT = 8'h42;
  localparam logic [7:0] HI_REPEAT_MEM = 8'h4b;
  localparam logic [7:0] HI_REPEAT_IMM = 8'hcb;

  // Operand timing: addresses at or above this limit are off-chip
  localparam logic [15:0] INTERNAL_LIMIT = 16'h0220;
  localparam logic [1:0] EXT_WAIT_CYCLES = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE, OP_SUM, OP_MINUS, OP_LOAD_ACC, OP_STORE_HIGH, OP_STORE_LOW,
    OP_SUM_LONG, OP_MINUS_LONG, OP_CONJ_LONG, OP_SUM_SHORT, OP_MINUS_SHORT, OP_LOAD_SHORT,
    OP_MAGNITUDE, OP_INVERT, OP_ROTATE_LEFT, OP_SHIFT_LEFT,
    OP_SUM_CARRY, OP_SUM_HIGH, OP_SUM_ULOW, OP_SUM_TSHIFT, OP_CONJ, OP_DISJ,
    OP_MINUS_BORROW, OP_COND_MINUS, OP_MINUS_HIGH, OP_MINUS_ULOW, OP_LOAD_TSHIFT,
    OP_REPEAT_MEM, OP_REPEAT_IMM
  } op_e;

  typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_EXEC, ST_WAIT} state_e;

endpackage : dsp_decode_pkg

// *** dsp_accumulator_instruction_decoder.sv ***
// Fetch, decode and operand addressing for the accumulator instruction group.
// Assumes a classic Wishbone master feeding instruction words and operands; single clock.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module dsp_accumulator_instruction_decoder (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic execValid,
  output dsp_decode_pkg::op_e execOp,
  output logic [15:0] dataAddr,
  output logic dataExternal,
  output logic [31:0] operandShifted,
  output logic [3:0] portNumber,
  output logic [1:0] productShift,
  output logic [1:0] compareMode,
  output logic [2:0] auxSelect,
  output logic [2:0] accShift,
  output logic [3:0] bitCode
);

  typedef struct packed {
    dsp_decode_pkg::state_e st;
    logic ack;
    logic [31:0] rdata;
    logic pfValid;
    logic [15:0] pfWord;
    logic [15:0] cur;
    logic [15:0] imm;
    logic [15:0] operand;
    logic [8:0] page;
    logic [2:0] auxPtr;
    logic signExt;
    logic [7:0][15:0] aux;
    logic [7:0] repCnt;
    logic repActive;
    logic tail;
    logic [1:0] waitCnt;
    logic execValid;
    dsp_decode_pkg::op_e execOp;
    logic [15:0] dataAddr;
    logic dataExternal;
    logic [31:0] shifted;
    logic [3:0] portNum;
    logic [1:0] prodShift;
    logic [1:0] cmpMode;
    logic [2:0] auxSel;
    logic [2:0] accShift;
    logic [3:0] bitCode;
  } state_s;

  state_s q;
  state_s s;
  logic [1:0] rstSync;
  logic rstnInt;

  // Reset is released through two flops so that the state struct leaves reset cleanly
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstnInt = rstSync[1];

  function automatic dsp_decode_pkg::op_e decodeOp(input logic [15:0] w);
    dsp_decode_pkg::op_e r;
    r = dsp_decode_pkg::OP_NONE;
    case (w[15:12])
      dsp_decode_pkg::NIB_SUM: r = dsp_decode_pkg::OP_SUM;
      dsp_decode_pkg::NIB_MINUS: r = dsp_decode_pkg::OP_MINUS;
      dsp_decode_pkg::NIB_LOAD: r = dsp_decode_pkg::OP_LOAD_ACC;
      dsp_decode_pkg::NIB_LONG:
      begin
        case (w[7:0])
          dsp_decode_pkg::LO_SUM_LONG: r = dsp_decode_pkg::OP_SUM_LONG;
          dsp_decode_pkg::LO_MINUS_LONG: r = dsp_decode_pkg::OP_MINUS_LONG;
          dsp_decode_pkg::LO_CONJ_LONG: r = dsp_decode_pkg::OP_CONJ_LONG;
          default: r = dsp_decode_pkg::OP_NONE;
        endcase
      end
      default:
      begin
        if (w[15:11] == dsp_decode_pkg::TOP_STORE_HIGH)
          r = dsp_decode_pkg::OP_STORE_HIGH;
        else if (w[15:11] == dsp_decode_pkg::TOP_STORE_LOW)
          r = dsp_decode_pkg::OP_STORE_LOW;
        else
        begin
          case (w[15:8])
            dsp_decode_pkg::HI_SUM_SHORT: r = dsp_decode_pkg::OP_SUM_SHORT;
            dsp_decode_pkg::HI_MINUS_SHORT: r = dsp_decode_pkg::OP_MINUS_SHORT;
            dsp_decode_pkg::HI_LOAD_SHORT: r = dsp_decode_pkg::OP_LOAD_SHORT;
            dsp_decode_pkg::HI_ACC_ONLY:
            begin
              case (w[7:0])
                dsp_decode_pkg::LO_MAGNITUDE: r = dsp_decode_pkg::OP_MAGNITUDE;
                dsp_decode_pkg::LO_INVERT: r = dsp_decode_pkg::OP_INVERT;
                dsp_decode_pkg::LO_ROTATE_LEFT: r = dsp_decode_pkg::OP_ROTATE_LEFT;
                dsp_decode_pkg::LO_SHIFT_LEFT: r = dsp_decode_pkg::OP_SHIFT_LEFT;
                default: r = dsp_decode_pkg::OP_NONE;
              endcase
            end
            dsp_decode_pkg::HI_SUM_CARRY: r = dsp_decode_pkg::OP_SUM_CARRY;
            dsp_decode_pkg::HI_SUM_HIGH: r = dsp_decode_pkg::OP_SUM_HIGH;
            dsp_decode_pkg::HI_SUM_ULOW: r = dsp_decode_pkg::OP_SUM_ULOW;
            dsp_decode_pkg::HI_SUM_TSHIFT: r = dsp_decode_pkg::OP_SUM_TSHIFT;
            dsp_decode_pkg::HI_CONJ: r = dsp_decode_pkg::OP_CONJ;
            dsp_decode_pkg::HI_DISJ: r = dsp_decode_pkg::OP_DISJ;
            dsp_decode_pkg::HI_MINUS_BORROW: r = dsp_decode_pkg::OP_MINUS_BORROW;
            dsp_decode_pkg::HI_COND_MINUS: r = dsp_decode_pkg::OP_COND_MINUS;
            dsp_decode_pkg::HI_MINUS_HIGH: r = dsp_decode_pkg::OP_MINUS_HIGH;
            dsp_decode_pkg::HI_MINUS_ULOW: r = dsp_decode_pkg::OP_MINUS_ULOW;
            dsp_decode_pkg::HI_LOAD_TSHIFT: r = dsp_decode_pkg::OP_LOAD_TSHIFT;
            dsp_decode_pkg::HI_REPEAT_MEM: r = dsp_decode_pkg::OP_REPEAT_MEM;
            dsp_decode_pkg::HI_REPEAT_IMM: r = dsp_decode_pkg::OP_REPEAT_IMM;
            default: r = dsp_decode_pkg::OP_NONE;
          endcase
        end
      end
    endcase
    return r;
  endfunction : decodeOp

  function automatic logic usesMemory(input dsp_decode_pkg::op_e op);
    logic r;
    case (op)
      dsp_decode_pkg::OP_NONE, dsp_decode_pkg::OP_SUM_LONG, dsp_decode_pkg::OP_MINUS_LONG,
      dsp_decode_pkg::OP_CONJ_LONG, dsp_decode_pkg::OP_SUM_SHORT, dsp_decode_pkg::OP_MINUS_SHORT,
      dsp_decode_pkg::OP_LOAD_SHORT, dsp_decode_pkg::OP_MAGNITUDE, dsp_decode_pkg::OP_INVERT,
      dsp_decode_pkg::OP_ROTATE_LEFT, dsp_decode_pkg::OP_SHIFT_LEFT, dsp_decode_pkg::OP_REPEAT_IMM: r = 1'b0;
      default: r = 1'b1;
    endcase
    return r;
  endfunction : usesMemory

  function automatic logic isLong(input dsp_decode_pkg::op_e op);
    return (op == dsp_decode_pkg::OP_SUM_LONG) || (op == dsp_decode_pkg::OP_MINUS_LONG) ||
           (op == dsp_decode_pkg::OP_CONJ_LONG);
  endfunction : isLong

  function automatic logic [15:0] bitRev(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15 - i];
    return r;
  endfunction : bitRev

  // Bit-reversed steps: reverse, add or subtract, reverse back, so the carry or borrow runs from MSB downward
  function automatic logic [15:0] nextAux(input logic [15:0] base, input logic [15:0] idx, input logic [2:0] m);
    logic [15:0] r;
    case (m)
      dsp_decode_pkg::MOD_DEC: r = base - 16'h0001;
      dsp_decode_pkg::MOD_INC: r = base + 16'h0001;
      dsp_decode_pkg::MOD_SUB_IDX: r = base - idx;
      dsp_decode_pkg::MOD_ADD_IDX: r = base + idx;
      dsp_decode_pkg::MOD_REV_INC: r = bitRev(bitRev(base) + bitRev(idx));
      dsp_decode_pkg::MOD_REV_DEC: r = bitRev(bitRev(base) - bitRev(idx));
      default: r = base;
    endcase
    return r;
  endfunction : nextAux

  // Low bits always zero-filled; high bits follow the sign-extension mode
  function automatic logic [31:0] shiftOperand(input logic [15:0] v, input logic [3:0] sh, input logic sx);
    logic [31:0] ext;
    ext = sx ? {{16{v[15]}}, v} : {16'h0000, v};
    return ext << sh;
  endfunction : shiftOperand

  function automatic logic [31:0] laneWrite(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    for (int b = 0; b < 4; b++)
      r[b * 8 +: 8] = sel[b] ? nw[b * 8 +: 8] : old[b * 8 +: 8];
    return r;
  endfunction : laneWrite

  dsp_decode_pkg::op_e curOp;
  dsp_decode_pkg::op_e pfOp;
  assign curOp = decodeOp(q.cur);
  assign pfOp = decodeOp(q.pfWord);

  always_comb
  begin
    logic req;
    logic doFinish;
    logic [15:0] addr;
    logic [15:0] src;
    logic [3:0] sh;
    logic [31:0] ctrlWord;
    logic [31:0] wv;
    logic mem;
    req = 1'b0;
    doFinish = 1'b0;
    addr = 16'h0000;
    src = 16'h0000;
    sh = 4'h0;
    ctrlWord = 32'h0000_0000;
    wv = 32'h0000_0000;
    mem = 1'b0;
    s = q;
    s.ack = 1'b0;
    s.execValid = 1'b0;

    case (q.st)
      dsp_decode_pkg::ST_IDLE:
      begin
        if (q.pfValid)
        begin
          s.cur = q.pfWord;
          s.pfValid = 1'b0;
          s.st = isLong(pfOp) ? dsp_decode_pkg::ST_SECOND : dsp_decode_pkg::ST_EXEC;
        end
      end
      dsp_decode_pkg::ST_SECOND:
      begin
        if (q.pfValid)
        begin
          s.imm = q.pfWord;
          s.pfValid = 1'b0;
          s.st = dsp_decode_pkg::ST_EXEC;
        end
      end
      dsp_decode_pkg::ST_EXEC:
      begin
        mem = usesMemory(curOp);
        // The register is read before its modification is written back
        addr = q.cur[dsp_decode_pkg::MODE_BIT] ? q.aux[q.auxPtr]
          : {q.page, q.cur[dsp_decode_pkg::OFFSET_W-1:0]};
        if (mem && q.cur[dsp_decode_pkg::MODE_BIT])
        begin
          s.aux[q.auxPtr] = nextAux(q.aux[q.auxPtr], q.aux[0], q.cur[dsp_decode_pkg::MOD_LSB +: 3]);
          if (q.cur[dsp_decode_pkg::NEXT_AUXPTR_BIT])
            s.auxPtr = q.cur[dsp_decode_pkg::AUXPTR_W-1:0];
        end
        case (curOp)
          dsp_decode_pkg::OP_SUM, dsp_decode_pkg::OP_MINUS, dsp_decode_pkg::OP_LOAD_ACC:
          begin
            src = q.operand;
            sh = q.cur[dsp_decode_pkg::SHIFT_LSB +: 4];
          end
          dsp_decode_pkg::OP_SUM_LONG, dsp_decode_pkg::OP_MINUS_LONG, dsp_decode_pkg::OP_CONJ_LONG:
          begin
            src = q.imm;
            sh = q.cur[dsp_decode_pkg::SHIFT_LSB +: 4];
          end
          dsp_decode_pkg::OP_SUM_SHORT, dsp_decode_pkg::OP_MINUS_SHORT, dsp_decode_pkg::OP_LOAD_SHORT:
            src = {8'h00, q.cur[7:0]};
          default: src = q.operand;
        endcase
        if (curOp == dsp_decode_pkg::OP_REPEAT_IMM)
          s.repCnt = q.cur[7:0];
        else if (curOp == dsp_decode_pkg::OP_REPEAT_MEM)
          s.repCnt = q.operand[7:0];
        s.execValid = 1'b1;
        s.execOp = curOp;
        s.dataAddr = mem ? addr : 16'h0000;
        s.dataExternal = mem && (addr >= dsp_decode_pkg::INTERNAL_LIMIT);
        s.shifted = shiftOperand(src, sh, q.signExt && !q.cur[dsp_decode_pkg::MODE_BIT + 8]);
        s.portNum = q.cur[dsp_decode_pkg::SHIFT_LSB +: 4];
        s.prodShift = q.cur[1:0];
        s.cmpMode = q.cur[1:0];
        s.auxSel = q.cur[dsp_decode_pkg::SHIFT_LSB +: 3];
        s.accShift = q.cur[dsp_decode_pkg::SHIFT_LSB +: 3];
        s.bitCode = q.cur[dsp_decode_pkg::SHIFT_LSB +: 4];
        // Later repetitions reuse the fetched operand path and skip the off-chip wait
        if (mem && (addr >= dsp_decode_pkg::INTERNAL_LIMIT) && !q.tail)
        begin
          s.st = dsp_decode_pkg::ST_WAIT;
          s.waitCnt = dsp_decode_pkg::EXT_WAIT_CYCLES - 2'h1;
        end
        else
          doFinish = 1'b1;
      end
      dsp_decode_pkg::ST_WAIT:
      begin
        if (q.waitCnt == 2'h0)
          doFinish = 1'b1;
        else
          s.waitCnt = q.waitCnt - 2'h1;
      end
      default: s.st = dsp_decode_pkg::ST_IDLE;
    endcase

    if (doFinish)
    begin
      if (q.repActive && (q.repCnt != 8'h00))
      begin
        s.repCnt = q.repCnt - 8'h01;
        s.tail = 1'b1;
        s.st = dsp_decode_pkg::ST_EXEC;
      end
      else
      begin
        s.tail = 1'b0;
        s.repActive = (curOp == dsp_decode_pkg::OP_REPEAT_IMM) || (curOp == dsp_decode_pkg::OP_REPEAT_MEM);
        s.st = dsp_decode_pkg::ST_IDLE;
      end
    end

    // Register bus: one ack per request; a full prefetch slot holds the instruction write off
    req = wbCyc && wbStb && !q.ack;
    ctrlWord = 32'h0000_0000;
    ctrlWord[dsp_decode_pkg::CTRL_PAGE_LSB +: dsp_decode_pkg::PAGE_W] = q.page;
    ctrlWord[dsp_decode_pkg::CTRL_AUXPTR_LSB +: dsp_decode_pkg::AUXPTR_W] = q.auxPtr;
    ctrlWord[dsp_decode_pkg::CTRL_SIGNEXT_BIT] = q.signExt;
    if (req)
    begin
      s.ack = 1'b1;
      s.rdata = 32'h0000_0000;
      if (wbAdr[7:dsp_decode_pkg::AUX_BLOCK_LSB] == dsp_decode_pkg::OFS_AUX_BASE[7:dsp_decode_pkg::AUX_BLOCK_LSB])
      begin
        s.rdata = {16'h0000, s.aux[wbAdr[dsp_decode_pkg::AUX_SEL_LSB +: 3]]};
        if (wbWe)
        begin
          wv = laneWrite(s.rdata, wbDatI, wbSel);
          s.aux[wbAdr[dsp_decode_pkg::AUX_SEL_LSB +: 3]] = wv[15:0];
        end
      end
      else
      begin
        case (wbAdr)
          dsp_decode_pkg::OFS_INSTR:
          begin
            s.rdata = {16'h0000, q.cur};
            if (wbWe && q.pfValid)
              s.ack = 1'b0;
            else if (wbWe)
            begin
              wv = laneWrite({16'h0000, q.pfWord}, wbDatI, wbSel);
              s.pfWord = wv[15:0];
              s.pfValid = 1'b1;
            end
          end
          dsp_decode_pkg::OFS_CTRL:
          begin
            s.rdata = ctrlWord;
            if (wbWe)
            begin
              wv = laneWrite(ctrlWord, wbDatI, wbSel);
              s.page = wv[dsp_decode_pkg::CTRL_PAGE_LSB +: dsp_decode_pkg::PAGE_W];
              s.auxPtr = wv[dsp_decode_pkg::CTRL_AUXPTR_LSB +: dsp_decode_pkg::AUXPTR_W];
              s.signExt = wv[dsp_decode_pkg::CTRL_SIGNEXT_BIT];
            end
          end
          dsp_decode_pkg::OFS_OPERAND:
          begin
            s.rdata = {16'h0000, q.operand};
            if (wbWe)
            begin
              wv = laneWrite({16'h0000, q.operand}, wbDatI, wbSel);
              s.operand = wv[15:0];
            end
          end
          dsp_decode_pkg::OFS_STATUS:
            s.rdata = {16'h0000, 2'(q.st), q.pfValid, q.repActive, q.tail, 3'h0, q.repCnt};
          dsp_decode_pkg::OFS_DADDR: s.rdata = {15'h0000, q.dataExternal, q.dataAddr};
          dsp_decode_pkg::OFS_SHIFT_LO: s.rdata = {16'h0000, q.shifted[15:0]};
          dsp_decode_pkg::OFS_SHIFT_HI: s.rdata = {16'h0000, q.shifted[31:16]};
          default: s.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
      q <= '0;
    else
      q <= s;
  end

  assign wbDatO = q.rdata;
  assign wbAck = q.ack;
  assign execValid = q.execValid;
  assign execOp = q.execOp;
  assign dataAddr = q.dataAddr;
  assign dataExternal = q.dataExternal;
  assign operandShifted = q.shifted;
  assign portNumber = q.portNum;
  assign productShift = q.prodShift;
  assign compareMode = q.cmpMode;
  assign auxSelect = q.auxSel;
  assign accShift = q.accShift;
  assign bitCode = q.bitCode;

endmodule : dsp_accumulator_instruction_decoder

// *** dsp_decoder_assertions.sv ***
// Port-level checks for the decoder: bus handshake, exec outputs and field ties.
// Assumes it is bound to the decoder top and that reset low clears every output.
`timescale 1ns/1ps
module decoder_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic [7:0] wbAdr,
  input wire logic wbAck,
  input wire logic execValid,
  input wire dsp_decode_pkg::op_e execOp,
  input wire logic [15:0] dataAddr,
  input wire logic dataExternal,
  input wire logic [31:0] operandShifted,
  input wire logic [3:0] portNumber,
  input wire logic [1:0] productShift,
  input wire logic [1:0] compareMode,
  input wire logic [2:0] auxSelect,
  input wire logic [2:0] accShift,
  input wire logic [3:0] bitCode
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_ackPulse; wbAck |=> !wbAck; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack held over one cycle");
  // Only the instruction register may stall while the prefetch slot is full
  property p_ackAnswer; wbCyc && wbStb && !wbAck && wbAdr != 8'h00 |=> wbAck; endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("register access not answered next cycle");
  property p_ext; execValid |-> dataExternal == (dataAddr >= dsp_decode_pkg::INTERNAL_LIMIT); endproperty
  a_ext: assert property (p_ext) else $error("external flag disagrees with address");
  property p_fields;
    execValid |-> portNumber[2:0] == auxSelect && auxSelect == accShift && productShift == compareMode
      && bitCode == portNumber;
  endproperty
  a_fields: assert property (p_fields) else $error("instruction fields disagree");
  property p_accOnly;
    execValid && execOp inside {[dsp_decode_pkg::OP_MAGNITUDE:dsp_decode_pkg::OP_SHIFT_LEFT]}
      |-> dataAddr == 16'h0000;
  endproperty
  a_accOnly: assert property (p_accOnly) else $error("accumulator-only op drove an address");
  property p_short;
    execValid && execOp inside {[dsp_decode_pkg::OP_SUM_SHORT:dsp_decode_pkg::OP_LOAD_SHORT]}
      |-> operandShifted[31:8] == 24'h000000 && dataAddr == 16'h0000;
  endproperty
  a_short: assert property (p_short) else $error("short immediate wider than eight bits");
  property p_lowZero;
    execValid && execOp == dsp_decode_pkg::OP_LOAD_ACC |-> (operandShifted & ((32'h1 << portNumber) - 32'h1)) == 32'h0;
  endproperty
  a_lowZero: assert property (p_lowZero) else $error("vacated low bits not zero");
  property p_hold; !execValid |-> $stable(execOp) && $stable(dataAddr); endproperty
  a_hold: assert property (p_hold) else $error("exec outputs moved without a pulse");
  c_ext: cover property (execValid && dataExternal);
  c_long: cover property (execValid && execOp == dsp_decode_pkg::OP_SUM_LONG);
  c_repeat: cover property (execValid ##1 execValid);
endmodule : decoder_checker

// *** program_rom.sv ***
// Program store standing in for external program memory, one opcode word per index.
// Assumes the bench copies each word into the decoder's instruction register.
`timescale 1ns/1ps
module program_rom (
  input wire logic [4:0] idx,
  output logic [15:0] word
);
  // Memory forms use offset 7f so that the top of a page is reached
  localparam logic [15:0] WORDS [23] = '{
    16'h007f, 16'h107f, 16'h207f,
    16'h687f, 16'h607f,
    16'hcc05, 16'hcd05, 16'hca05,
    16'hce1b, 16'hce27, 16'hce34, 16'hce18,
    16'h437f, 16'h487f, 16'h497f, 16'h4a7f, 16'h4e7f, 16'h4d7f,
    16'h4f7f, 16'h477f, 16'h447f, 16'h457f, 16'h427f
  };
  assign word = (idx < 5'h17) ? WORDS[idx] : 16'h0000;
endmodule : program_rom

// *** dsp_accumulator_instruction_decoder_bench.sv ***
// Self-checking bench: Wishbone master tasks feed words and compare the exec outputs.
// Assumes the package, decoder, checker and program_rom are compiled first.
`timescale 1ns/1ps
module dsp_accumulator_instruction_decoder_bench;
  logic clk, rstn, wbCyc, wbStb, wbWe, wbAck, execValid, dataExternal, prevInv;
  logic [7:0] wbAdr;
  logic [3:0] wbSel, portNumber, bitCode;
  logic [31:0] wbDatI, wbDatO, operandShifted, rd;
  logic [15:0] dataAddr, romWord;
  logic [1:0] productShift, compareMode;
  logic [2:0] auxSelect, accShift;
  logic [4:0] romIdx;
  dsp_decode_pkg::op_e execOp;
  int miscompares, nChecks, invPulses, invAdj;
  // Aux 5 after one step from 0100 with index 0008, per modify code
  logic [15:0] auxAfter [8] = '{16'h0100, 16'h00ff, 16'h0101, 16'h0100, 16'h010f, 16'h00f8, 16'h0108, 16'h0108};
  dsp_accumulator_instruction_decoder dut_u (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .execValid(execValid),
    .execOp(execOp), .dataAddr(dataAddr), .dataExternal(dataExternal), .operandShifted(operandShifted),
    .portNumber(portNumber), .productShift(productShift), .compareMode(compareMode), .auxSelect(auxSelect),
    .accShift(accShift), .bitCode(bitCode));
  program_rom rom_u (.idx(romIdx), .word(romWord));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (execValid === 1'b1 && execOp === dsp_decode_pkg::OP_INVERT)
    begin
      invPulses++;
      if (prevInv) invAdj++;
    end
    prevInv <= execValid === 1'b1 && execOp === dsp_decode_pkg::OP_INVERT;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    for (n = 0; n < 400 && wbAck !== 1'b1; n++) @(posedge clk);
    rd = wbDatO;
    if (n == 400)
    begin
      miscompares++;
      print_verdict();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask : wbXfer
  task automatic runWord(input logic [15:0] w);
    int n;
    wbXfer(1'b1, dsp_decode_pkg::OFS_INSTR, {16'h0000, w});
    for (n = 0; n < 50 && execValid !== 1'b1; n++) @(posedge clk);
    if (n == 50)
    begin
      miscompares++;
      print_verdict();
    end
  endtask : runWord
  task automatic repeatRun(input logic [15:0] rw, input int cnt);
    invPulses = 0;
    invAdj = 0;
    runWord(rw);
    wbXfer(1'b1, dsp_decode_pkg::OFS_INSTR, 32'h0000ce27);
    repeat (cnt + 20) @(posedge clk);
    check("repeat count", invPulses, cnt);
    check("repeat back to back", invAdj, cnt - 1);
  endtask : repeatRun
  initial
  begin
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatI = 32'h00000000;
    romIdx = 5'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wbXfer(1'b0, dsp_decode_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    wbXfer(1'b1, 8'h40, 32'hffffffff);
    wbXfer(1'b0, 8'h40, 32'h0);
    check("unmapped read", rd, 32'h0);
    wbXfer(1'b1, dsp_decode_pkg::OFS_CTRL, 32'h000001a5);
    wbXfer(1'b1, dsp_decode_pkg::OFS_OPERAND, 32'h00000123);
    runWord(16'h2355);
    check("direct addr", 32'(dataAddr), 32'h0000d2d5);
    check("load shift", operandShifted, 32'h00000918);
    check("fields", 32'({portNumber, productShift, compareMode, auxSelect, accShift, bitCode}),
      32'h0000d5b3);
    wbXfer(1'b1, dsp_decode_pkg::OFS_DADDR, 32'h0);
    wbXfer(1'b0, dsp_decode_pkg::OFS_DADDR, 32'h0);
    check("daddr read-only", rd & 32'h1ffff, 32'h0001d2d5);
    wbXfer(1'b1, dsp_decode_pkg::OFS_CTRL, 32'h00001000);
    wbXfer(1'b1, dsp_decode_pkg::OFS_OPERAND, 32'h00008001);
    runWord(16'h2400);
    check("sign extend", operandShifted, 32'hfff80010);
    wbXfer(1'b1, dsp_decode_pkg::OFS_CTRL, 32'h000001ff);
    for (int i = 0; i < 23; i++)
    begin
      romIdx = 5'(i);
      @(posedge clk);
      runWord(romWord);
      check("opcode", 32'(execOp), 32'(i < 5 ? i + 1 : i + 4));
      if (i < 5 || i > 11) check("top of page", 32'(dataAddr), 32'h0000ffff);
      if (i > 4 && i < 8) check("short imm", operandShifted, 32'h5);
    end
    for (int i = 0; i < 3; i++)
    begin
      wbXfer(1'b1, dsp_decode_pkg::OFS_INSTR, {24'h0000d3, 8'(i + 2)});
      runWord(16'h1234);
      check("long op", 32'(execOp), 32'(i + 6));
      check("long imm", operandShifted, 32'h000091a0);
    end
    wbXfer(1'b1, dsp_decode_pkg::OFS_CTRL, 32'h00000a00);
    wbXfer(1'b1, dsp_decode_pkg::OFS_AUX_BASE, 32'h00000008);
    for (int m = 0; m < 8; m++)
    begin
      wbXfer(1'b1, 8'h34, 32'h00000100);
      runWord({8'h00, 1'b1, 3'(m), 4'h0});
      check("indirect addr", 32'(dataAddr), 32'h00000100);
      wbXfer(1'b0, 8'h34, 32'h0);
      check("aux step", rd & 32'hffff, 32'(auxAfter[m]));
    end
    wbXfer(1'b1, 8'h2c, 32'h00000abc);
    runWord(16'h008b);
    wbXfer(1'b0, dsp_decode_pkg::OFS_CTRL, 32'h0);
    check("pointer load", (rd >> 9) & 32'h7, 32'h3);
    runWord(16'h0080);
    check("pointer selects", 32'(dataAddr), 32'h00000abc);
    repeatRun(16'hcb03, 4);
    repeatRun(16'hcbff, 256);
    wbXfer(1'b1, dsp_decode_pkg::OFS_CTRL, 32'h0);
    wbXfer(1'b1, dsp_decode_pkg::OFS_OPERAND, 32'h00000002);
    repeatRun(16'h4b00, 3);
    print_verdict();
  end
endmodule : dsp_accumulator_instruction_decoder_bench
bind dsp_accumulator_instruction_decoder decoder_checker chk_u (.clk(clk), .rstn(rstn), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbAdr(wbAdr), .wbAck(wbAck), .execValid(execValid), .execOp(execOp), .dataAddr(dataAddr),
  .dataExternal(dataExternal), .operandShifted(operandShifted), .portNumber(portNumber),
  .productShift(productShift), .compareMode(compareMode), .auxSelect(auxSelect), .accShift(accShift),
  .bitCode(bitCode));
